// ===== fsc_frame_size.sv
/*
 * Frame size configuration bank with clock domain crossing.
 * Holds pixels per line and lines per frame in a bus-side register and
 * carries them to the pixel domain by a toggle handshake, so a word is
 * never taken half-changed. Without the register option the sizes are
 * constants. Assumes a single-cycle register port on bus_clk and that
 * bus_clk runs no more than 128 times faster than pix_clk.
 */
`timescale 1ns/1ns
`include "fsc_regs.svh"

// Operation
// (RQ1) Reset low half to pixels default
// (RQ2) Reset high half to lines default
// (RQ3) No register option: fixed constant sizes
// (RQ4) Maximum line length 32..7680 sizes buffers
// (RQ5) Master writes pixels below maximum only
// (RQ6) Constant mode: maximum equals pixels per line
// (RQ7) Block synchronises all cross-domain values
// (RQ8) Bus clock at most 128x pixel
// (RQ9) Bus clock within pixel clock limit
// (RQ10) Component width 8, 10 or 12
// (RQ11) 32-bit register: pixels low, lines high
module fsc_frame_size
    import fsc_pkg::*;
#(
    parameter bit HAS_REGS = 1'b1,                            // Register option built in
    parameter logic [15:0] ACTIVE_COLS = `FSC_ACTIVE_COLS_DEF, // Pixels per line default
    parameter logic [15:0] ACTIVE_ROWS = `FSC_ACTIVE_ROWS_DEF, // Lines per frame default
    parameter int MAX_COLS = `FSC_MAX_COLS_DEF,               // Longest line
    parameter int DATA_WIDTH = `FSC_DATA_WIDTH_DEF            // Pixel component width
) (
    input wire logic bus_clk,                  // Register bus clock
    input wire logic bus_rst,                  // Bus reset, sync, active high
    input wire fsc_reg_req_s reg_req,          // Register write/read strobes
    output logic [`FSC_DIM_W-1:0] reg_rdata,   // Read data, held after a read
    output logic reg_busy,                     // Update still crossing over
    input wire logic pix_clk,                  // Pixel clock
    input wire logic pix_rst,                  // Pixel reset, sync, active high
    output fsc_dim_s pix_dim,                  // Sizes in the pixel domain
    output logic pix_dim_upd                   // One-cycle pulse on new sizes
);
    // (RQ6) Constant mode makes the maximum the active width
    localparam int EFF_MAX = HAS_REGS ? MAX_COLS : int'(ACTIVE_COLS);
    // (RQ4) Line buffer address width follows the maximum
    localparam int LB_AW = $clog2(EFF_MAX);

    // (RQ4) Reject illegal build settings at elaboration
    if (EFF_MAX < `FSC_MAX_COLS_MIN || EFF_MAX > `FSC_MAX_COLS_MAX) begin : g_bad_max
        $error("Maximum line length out of range");
    end
    // (RQ10) Only 8, 10 or 12 bit components
    if (DATA_WIDTH != 8 && DATA_WIDTH != 10 && DATA_WIDTH != 12) begin : g_bad_dw
        $error("Pixel component width must be 8, 10 or 12");
    end

    // Reset value of the dimension word, pixels low and lines high
    localparam fsc_dim_s DIM_RST = '{lines: ACTIVE_ROWS, pixels: ACTIVE_COLS};

    // Bus-side state
    typedef struct packed {
        fsc_dim_s dim;                    // Programmed dimensions
        fsc_dim_s shadow;                 // Word frozen while crossing
        logic [`FSC_DIM_W-1:0] rdata;     // Read data register
        logic req_tgl;                    // Toggles once per update
        logic pend;                       // A write or the reset value waits to be sent
        fsc_xfer_e xs;                    // Handshake state
        logic busy;                       // Mirrors the busy output
    } fsc_bus_s;

    // Pixel-side state
    typedef struct packed {
        fsc_dim_s dim;                    // Sizes used by the datapath
        logic ack_tgl;                    // Echo of the request toggle
        logic upd;                        // Update pulse
    } fsc_pix_s;

    fsc_bus_s b_q;
    fsc_bus_s b_d;
    fsc_pix_s p_q;
    fsc_pix_s p_d;
    logic req_at_pix;                     // Request toggle seen on pix_clk
    logic ack_at_bus;                     // Acknowledge toggle seen on bus_clk

    // (RQ7) Request toggle into the pixel domain
    fsc_sync u_req_sync (
        .clk(pix_clk),
        .rst(pix_rst),
        .din(b_q.req_tgl),
        .dout(req_at_pix)
    );

    // (RQ7) Acknowledge toggle back to the bus domain
    fsc_sync u_ack_sync (
        .clk(bus_clk),
        .rst(bus_rst),
        .din(p_q.ack_tgl),
        .dout(ack_at_bus)
    );

    // Bus side: register writes, readback, handshake launch
    always_comb begin
        b_d = b_q;
        if (HAS_REGS) begin
            // (RQ11) Whole word written, both halves
            if (reg_req.wr) begin
                b_d.dim = fsc_dim_s'(reg_req.wdata);
                b_d.pend = 1'b1;
            end
            // (RQ11) Readback shows the programmed word
            if (reg_req.rd) begin
                b_d.rdata = b_q.dim;
            end
            unique case (b_q.xs)
                FSC_IDLE: begin
                    // A write or the reset value starts a crossing
                    if (b_q.pend) begin
                        b_d.shadow = b_q.dim;
                        b_d.pend = reg_req.wr;
                        b_d.xs = FSC_SEND;
                    end
                end
                FSC_SEND: begin
                    // (RQ7) Shadow held stable before the toggle flips
                    b_d.req_tgl = ~b_q.req_tgl;
                    b_d.xs = FSC_WAIT;
                end
                FSC_WAIT: begin
                    // Wait for the echo; a later write stays pending
                    if (ack_at_bus == b_q.req_tgl) begin
                        b_d.xs = FSC_IDLE;
                    end
                end
            endcase
            b_d.busy = (b_d.xs != FSC_IDLE) || b_d.pend;
        end
    end

    // Bus side registers
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            // (RQ1) (RQ2) Dimensions reset to the build defaults
            b_q.dim <= DIM_RST;
            b_q.shadow <= DIM_RST;
            b_q.rdata <= '0;
            b_q.req_tgl <= 1'b0;
            // Reset values are pushed across once after reset
            b_q.pend <= HAS_REGS;
            b_q.xs <= FSC_IDLE;
            b_q.busy <= HAS_REGS;
        end else begin
            b_q <= b_d;
        end
    end

    // Pixel side: take the shadow once the toggle has landed
    always_comb begin
        p_d = p_q;
        p_d.upd = 1'b0;
        if (HAS_REGS && (req_at_pix != p_q.ack_tgl)) begin
            // (RQ7) Shadow is stable here, sampled whole
            p_d.dim = b_q.shadow;
            p_d.ack_tgl = req_at_pix;
            p_d.upd = 1'b1;
        end
    end

    // Pixel side registers
    always_ff @(posedge pix_clk) begin
        if (pix_rst) begin
            // (RQ3) Constants stand here when no register option
            p_q.dim <= DIM_RST;
            p_q.ack_tgl <= 1'b0;
            p_q.upd <= 1'b0;
        end else begin
            p_q <= p_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = b_q.rdata;
    assign reg_busy = b_q.busy;
    assign pix_dim = p_q.dim;
    assign pix_dim_upd = p_q.upd;

    // Assertions, bus domain except the first, which runs on pix_clk
    // (RQ5) Master keeps the pixel count below the maximum
    // Watches the sizes the block hands on, not the master's own strobes
    a_ppl_below_max: assert property (@(posedge pix_clk) disable iff (pix_rst) // (RQ5)
        pix_dim_upd |-> (int'(pix_dim.pixels) < EFF_MAX))
        else $error("Pixels per line handed on at or above maximum");
    a_write_stores_word: assert property (@(posedge bus_clk) disable iff (bus_rst) // (RQ11)
        (HAS_REGS && reg_req.wr) |=> (b_q.dim == $past(reg_req.wdata)))
        else $error("Written word not held in the dimension register");
    a_read_returns_dim: assert property (@(posedge bus_clk) disable iff (bus_rst) // (RQ11)
        (HAS_REGS && reg_req.rd && !reg_req.wr) |=> (reg_rdata == $past(b_q.dim)))
        else $error("Readback differs from the dimension register");
    // Next-cycle form avoids a history value at the very first edge
    a_reset_dims: assert property (@(posedge bus_clk) // (RQ1)
        bus_rst |=> (b_q.dim.pixels == ACTIVE_COLS && b_q.dim.lines == ACTIVE_ROWS))
        else $error("Dimension register not at defaults after reset");
    a_shadow_stable: assert property (@(posedge bus_clk) disable iff (bus_rst) // (RQ7)
        (b_q.xs == FSC_WAIT) |=> $stable(b_q.shadow))
        else $error("Shadow changed while crossing");
    a_send_toggles: assert property (@(posedge bus_clk) disable iff (bus_rst) // (RQ7)
        (b_q.xs == FSC_SEND) |=> (b_q.req_tgl != $past(b_q.req_tgl)) ##0 (b_q.xs == FSC_WAIT))
        else $error("Request toggle not flipped on send");
    a_busy_when_pending: assert property (@(posedge bus_clk) disable iff (bus_rst) // (RQ7)
        (HAS_REGS && reg_req.wr) |=> reg_busy)
        else $error("Busy not raised after a write");

    // Assertions, pixel domain
    a_const_sizes: assert property (@(posedge pix_clk) disable iff (pix_rst) // (RQ3)
        !HAS_REGS |-> (pix_dim.pixels == ACTIVE_COLS && pix_dim.lines == ACTIVE_ROWS))
        else $error("Constant sizes changed");
    a_upd_loads_shadow: assert property (@(posedge pix_clk) disable iff (pix_rst) // (RQ7)
        pix_dim_upd |-> (pix_dim == $past(b_q.shadow)))
        else $error("Pixel sizes not taken from the shadow");
    a_dim_only_on_upd: assert property (@(posedge pix_clk) disable iff (pix_rst) // (RQ7)
        !pix_dim_upd |-> $stable(pix_dim))
        else $error("Pixel sizes changed without an update");
    a_lb_width: assert property (@(posedge pix_clk) // (RQ4)
        (LB_AW >= 5))
        else $error("Line buffer address too narrow");

    // Main scenarios
    c_write: cover property (@(posedge bus_clk) disable iff (bus_rst) reg_req.wr);
    c_write_while_busy: cover property (@(posedge bus_clk) disable iff (bus_rst) reg_req.wr && b_q.xs == FSC_WAIT);
    c_pix_update: cover property (@(posedge pix_clk) disable iff (pix_rst) pix_dim_upd);
endmodule

// ===== fsc_frame_size_tb.sv
/*
 * Self-checking bench for the frame size bank: one register instance
 * and one constant instance share the register port.
 * Assumes the design header and package are compiled first.
 */
`timescale 1ns/1ns

module fsc_frame_size_tb;
    import fsc_pkg::*;
    localparam logic [15:0] COLS = 16'h0028;  // Register instance pixels default
    localparam logic [15:0] ROWS = 16'h0019;  // Register instance lines default
    localparam logic [15:0] C_COLS = 16'h0020; // Constant instance pixels
    localparam logic [15:0] C_ROWS = 16'h0010; // Constant instance lines
    localparam int MAX_C = 64;                 // Short line keeps buffers small
    logic bus_clk = 1'b0;                      // Register clock
    logic pix_clk = 1'b0;                      // Pixel clock
    logic bus_rst = 1'b1;                      // Bus reset
    logic pix_rst = 1'b1;                      // Pixel reset
    fsc_reg_req_s reg_req = '0;                // Shared register port
    logic [31:0] rdata, rdata_c, v;            // Read data and scratch
    logic busy, busy_c, upd, upd_c;            // Status outputs
    fsc_dim_s dim, dim_c, last_dim;            // Sizes
    logic [7:0] upd_cnt;                       // Pulses seen by the sink
    int miscompares = 0;                       // Mismatches found
    int compares = 0;                          // Comparisons made

    // Bus runs slightly faster than pixel, far inside the ratio limit
    // ratio below 128x
    initial forever #5 bus_clk = ~bus_clk;
    initial forever #7 pix_clk = ~pix_clk;

    fsc_frame_size #(.HAS_REGS(1'b1), .ACTIVE_COLS(COLS), .ACTIVE_ROWS(ROWS), .MAX_COLS(MAX_C),
        .DATA_WIDTH(10)) i_fsc_frame_size (.bus_clk(bus_clk), .bus_rst(bus_rst), .reg_req(reg_req),
        .reg_rdata(rdata), .reg_busy(busy), .pix_clk(pix_clk), .pix_rst(pix_rst), .pix_dim(dim),
        .pix_dim_upd(upd));
    // Constant build: maximum equals the fixed line length
    // maximum equals pixels
    fsc_frame_size #(.HAS_REGS(1'b0), .ACTIVE_COLS(C_COLS), .ACTIVE_ROWS(C_ROWS), .MAX_COLS(32),
        .DATA_WIDTH(12)) i_fsc_frame_size_const (.bus_clk(bus_clk), .bus_rst(bus_rst),
        .reg_req(reg_req), .reg_rdata(rdata_c), .reg_busy(busy_c), .pix_clk(pix_clk),
        .pix_rst(pix_rst), .pix_dim(dim_c), .pix_dim_upd(upd_c));
    fsc_pix_sink i_fsc_pix_sink (.pix_clk(pix_clk), .pix_rst(pix_rst), .pix_dim(dim),
        .pix_dim_upd(upd), .last_dim(last_dim), .upd_cnt(upd_cnt));

    // Verdict and end of run
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write pulse
    task automatic wr_word(input logic [31:0] w);
        @(negedge bus_clk);
        reg_req.wr = 1'b1;
        reg_req.wdata = w;
        @(negedge bus_clk);
        reg_req.wr = 1'b0;
    endtask

    // One-cycle read pulse; data is settled by the next falling edge
    task automatic rd_word(output logic [31:0] r);
        @(negedge bus_clk);
        reg_req.rd = 1'b1;
        @(negedge bus_clk);
        r = rdata;
        reg_req.rd = 1'b0;
    endtask

    // Bounded wait for the crossing to finish
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(negedge bus_clk);
            n++;
        end
        if (busy !== 1'b0) begin
            miscompares++;
            $display("mismatch %0t busy never dropped", $time);
            finish_test();
        end
    endtask

    // Defaults in the register and pushed once to the pixel side
    task automatic t_defaults;
        wait_idle();
        check(32'(upd_cnt), 32'h0000_0001);
        check(last_dim, {ROWS, COLS});
        rd_word(v);
        check(v, {ROWS, COLS});
        check(32'(v[31:16]), 32'(ROWS));
    endtask

    // Boundary line length written, read back and carried over
    task automatic t_write;
        wr_word({16'h0123, 16'(MAX_C - 1)});
        check(32'(busy), 32'h0000_0001);
        wait_idle();
        check(32'(upd_cnt), 32'h0000_0002);
        check(last_dim, {16'h0123, 16'(MAX_C - 1)});
        rd_word(v);
        check(v, {16'h0123, 16'(MAX_C - 1)});
    endtask

    // Back-to-back writes: the last one wins on both sides
    task automatic t_back_to_back;
        @(negedge bus_clk);
        reg_req.wr = 1'b1;
        reg_req.wdata = 32'h0200_0011;
        @(negedge bus_clk);
        reg_req.wdata = 32'h0300_0022;
        @(negedge bus_clk);
        reg_req.wr = 1'b0;
        wait_idle();
        repeat (20) @(negedge bus_clk);
        wait_idle();
        check(last_dim, 32'h0300_0022);
        rd_word(v);
        check(v, 32'h0300_0022);
    endtask

    // Read together with a write returns the old word
    task automatic t_read_during_write;
        @(negedge bus_clk);
        reg_req.rd = 1'b1;
        reg_req.wr = 1'b1;
        reg_req.wdata = 32'h0400_0033;
        @(negedge bus_clk);
        v = rdata;
        reg_req.rd = 1'b0;
        reg_req.wr = 1'b0;
        check(v, 32'h0300_0022);
        wait_idle();
        check(last_dim, 32'h0400_0033);
    endtask

    // Constant build ignored every write above
    task automatic t_constant;
        check(dim_c, {C_ROWS, C_COLS});
        check(rdata_c, 32'h0000_0000);
        check(32'(busy_c), 32'h0000_0000);
        check(32'(upd_c), 32'h0000_0000);
        check(dim, 32'h0400_0033);
    endtask

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        $display("mismatch %0t run took too long", $time);
        finish_test();
    end

    // Main sequence: both resets together for five bus cycles
    initial begin
        repeat (5) @(negedge bus_clk);
        bus_rst = 1'b0;
        pix_rst = 1'b0;
        t_defaults();
        t_write();
        t_back_to_back();
        t_read_during_write();
        t_constant();
        finish_test();
    end
endmodule

// ===== fsc_pix_sink.sv
/*
 * Pixel-side datapath model: latches the sizes on each update pulse
 * and counts the pulses so the bench can tell how many crossings landed.
 * Assumes the design drives pix_dim and pix_dim_upd on pix_clk.
 */
`timescale 1ns/1ns

module fsc_pix_sink
    import fsc_pkg::*;
(
    input wire logic pix_clk,         // Pixel clock
    input wire logic pix_rst,         // Pixel reset, sync, active high
    input wire fsc_dim_s pix_dim,     // Sizes from the block
    input wire logic pix_dim_upd,     // Update pulse from the block
    output fsc_dim_s last_dim,        // Sizes taken at the last pulse
    output logic [7:0] upd_cnt        // Pulses seen since reset
);
    // Take the sizes only on the pulse, as a line buffer control would
    // pixel side capture
    always_ff @(posedge pix_clk) begin
        if (pix_rst) begin
            last_dim <= '0;
            upd_cnt <= 8'h00;
        end else if (pix_dim_upd) begin
            last_dim <= pix_dim;
            upd_cnt <= upd_cnt + 8'h01;
        end
    end
endmodule

// ===== fsc_pkg.sv
/*
 * Types shared by the frame size configuration block.
 * Assumes fsc_regs.svh is reachable on the include path.
 */
`include "fsc_regs.svh"

package fsc_pkg;
    // Frame dimensions as carried between domains
    typedef struct packed {
        logic [`FSC_HALF_W-1:0] lines;  // Lines per frame
        logic [`FSC_HALF_W-1:0] pixels; // Pixels per line
    } fsc_dim_s;

    // Register bus write/read port
    typedef struct packed {
        logic wr;                   // Write strobe, one cycle
        logic rd;                   // Read strobe, one cycle
        logic [`FSC_DIM_W-1:0] wdata; // Write data
    } fsc_reg_req_s;

    // Handshake states on the bus side
    typedef enum logic [1:0] {
        FSC_IDLE,
        FSC_SEND,
        FSC_WAIT
    } fsc_xfer_e;
endpackage

// ===== fsc_regs.svh
/*
 * Constants for the frame size configuration block: register layout,
 * build-time defaults and legal ranges.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// Frame dimension register fields
`define FSC_PPL_LSB 0
`define FSC_PPL_MSB 15
`define FSC_LPF_LSB 16
`define FSC_LPF_MSB 31
`define FSC_DIM_W 32
`define FSC_HALF_W 16

// Build-time defaults and maximum line length limits
`define FSC_ACTIVE_COLS_DEF 16'h0780
`define FSC_ACTIVE_ROWS_DEF 16'h0438
`define FSC_MAX_COLS_DEF 1920
`define FSC_MAX_COLS_MIN 32
`define FSC_MAX_COLS_MAX 7680
`define FSC_DATA_WIDTH_DEF 8

// Synchroniser depth and handshake constants
`define FSC_SYNC_STAGES 2
`define FSC_ZERO16 16'h0000
`define FSC_ONE16 16'h0001

`endif

// ===== fsc_sync.sv
/*
 * Two-flop level synchroniser into a destination clock.
 * Assumes the input is a quasi-static level from another domain.
 */
`timescale 1ns/1ns
`include "fsc_regs.svh"

module fsc_sync
    import fsc_pkg::*;
(
    input wire logic clk,   // Destination clock
    input wire logic rst,   // Synchronous reset, active high
    input wire logic din,   // Level from the far domain
    output logic dout       // Synchronised level
);
    // All state of the synchroniser
    typedef struct packed {
        logic [`FSC_SYNC_STAGES-1:0] stg; // Stage 0 feeds only stage 1
    } fsc_sync_s;

    fsc_sync_s st_q;
    fsc_sync_s st_d;

    // Shift the level along the chain
    always_comb begin
        st_d = st_q;
        st_d.stg = {st_q.stg[0], din};
    end

    // Register the chain
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.stg[`FSC_SYNC_STAGES-1];
endmodule
